// *** rtl/vme_window_pkg.sv ***
// Constants and types for the VMEbus slave window decode block
package vme_window_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [11:0] OFS_MODIFIER_FAULT_LOG = 12'hf88;
	localparam logic [11:0] OFS_ADDRESS_FAULT_LOG = 12'hf8c;
	localparam logic [11:0] OFS_WINDOW4_CONTROL = 12'hf90;
	localparam logic [11:0] OFS_WINDOW4_BASE = 12'hf94;
	localparam logic [11:0] OFS_WINDOW4_BOUND = 12'hf98;
	localparam logic [11:0] OFS_WINDOW4_OFFSET = 12'hf9c;
	localparam logic [11:0] OFS_WINDOW5_CONTROL = 12'hfa4;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTL_ACTIVE = 31;
	localparam int CTL_POSTED = 30;
	localparam int CTL_PREFETCH = 29;
	localparam int CTL_PD_LSB = 22;
	localparam int CTL_PRIV_LSB = 20;
	localparam int CTL_SPACE_LSB = 16;
	localparam int CTL_WIDE = 7;
	localparam int CTL_LOCK = 6;
	localparam int CTL_PCI_LSB = 0;
	localparam int LOG_AM_LSB = 26;
	localparam int LOG_IACK = 25;
	localparam int LOG_MULTI = 24;
	localparam int LOG_VALID = 23;
	localparam int W4_GRAIN = 12;
	localparam int W5_GRAIN = 16;

	// ----------------------------------------
	// Encodings
	// ----------------------------------------
	localparam logic [2:0] SPACE_A16 = 3'h0;
	localparam logic [2:0] SPACE_A24 = 3'h1;
	localparam logic [2:0] SPACE_A32 = 3'h2;
	localparam logic [2:0] SPACE_CUSTOM_ONE = 3'h6;
	localparam logic [2:0] SPACE_CUSTOM_TWO = 3'h7;
	localparam logic [2:0] AM_GRP_A16 = 3'h5;
	localparam logic [2:0] AM_GRP_A24 = 3'h7;
	localparam logic [2:0] AM_GRP_A32 = 3'h1;
	localparam logic [2:0] AM_GRP_CUSTOM_ONE = 3'h2;
	localparam logic [2:0] AM_GRP_CUSTOM_TWO = 3'h3;
	localparam logic [1:0] PCI_MEM = 2'h0;
	localparam logic [1:0] PCI_IO = 2'h1;
	localparam logic [1:0] PCI_CFG = 2'h2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [1:0] RST_PD = 2'h3;
	localparam logic [1:0] RST_PRIV = 2'h3;

	typedef struct packed {
		logic active;
		logic posted;
		logic prefetch;
		logic [1:0] pd_sel;
		logic [1:0] priv;
		logic [2:0] space;
		logic wide;
		logic lock;
		logic [1:0] pci_space;
	} window_ctl_t;

	localparam window_ctl_t RST_CTL = '{1'b0, 1'b0, 1'b0, RST_PD, RST_PRIV, SPACE_A16,
		1'b0, 1'b0, PCI_MEM};

	typedef struct packed {
		logic hit4;
		logic hit5;
		logic [31:0] pci_addr;
		logic [1:0] pci_space;
		logic post;
		logic prefetch;
		logic wide;
		logic lock;
	} dec_result_t;

endpackage : vme_window_pkg

// *** rtl/vme_slave_window_decode.sv ***
// VMEbus slave window decode, translation and posted-write fault log
`timescale 1ns/1ps
// Overview of operation
// - Posted write bus error captures its VMEbus address bits 31:1 into the fault log.
// - Fault address is meaningful only while the log valid flag is set.
// - Valid flag freezes logging; writing 1 clears it, writing 0 does nothing.
// - Multiple fault flag sets on any further error while logs are frozen.
// - No window answers unless the PCI master allow bit is set.
// - Only PCI memory space cycles are posted; I/O and configuration never.
// - Window decodes addresses at or above base and below bound.
// - Bound of zero removes the upper limit.
// - Destination address is source address plus the window offset.
// - Window 4 uses address bits 31:12 for base, bound and offset.
// - Space select: 001 A24, 010 A32, 110/111 custom; 000 A16 on window 4 only.
// - Program/data select: 01 data, 10 program, 11 both; resets to 11.
// - Privilege select: 01 non-privileged, 10 supervisor, 11 both; resets to 11.
// - Window active bit enables decode and resets to 0.
// - Posted-write allow bit lets writes be posted into the receive queue.
// - Prefetch allow bit permits read prefetch on the PCI side.
// - Wide PCI allow bit permits 64-bit PCI transactions.
// - Lock-on-RMW bit locks the PCI bus during VMEbus read-modify-write.
// - PCI space select: 00 memory, 01 I/O, 10 configuration, 11 reserved.
module vme_slave_window_decode #(
	parameter int REG_ADDR_W = 12
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_vme_sysrst_n,
	input wire logic [REG_ADDR_W-1:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [31:0] i_reg_wdata,
	output logic [31:0] o_reg_rdata,
	output logic o_reg_rvalid,
	input wire logic i_pci_master_allow,
	input wire logic i_pw_berr,
	input wire logic [31:0] i_pw_berr_addr,
	input wire logic [5:0] i_pw_berr_am,
	input wire logic i_pw_berr_iack,
	input wire logic [15:0] i_w5_base,
	input wire logic [15:0] i_w5_bound,
	input wire logic [15:0] i_w5_offset,
	input wire logic i_vme_req,
	input wire logic [31:0] i_vme_addr,
	input wire logic [5:0] i_vme_am,
	input wire logic i_vme_write,
	input wire logic i_vme_rmw,
	output logic o_dec_valid,
	output vme_window_pkg::dec_result_t o_dec
);

	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	if (REG_ADDR_W != 12) begin : g_addr_w_check
		$error("REG_ADDR_W must be 12");
	end

	// ----------------------------------------
	// Reset and state
	// ----------------------------------------
	logic rst;
	assign rst = !i_rst_n || !i_vme_sysrst_n;

	vme_window_pkg::window_ctl_t ctl4;
	vme_window_pkg::window_ctl_t ctl5;
	logic [19:0] base4;
	logic [19:0] bound4;
	logic [19:0] offset4;
	logic [30:0] fault_addr;
	logic [5:0] fault_am;
	logic fault_iack;
	logic fault_multi;
	logic fault_valid;

	logic wr_ctl4;
	logic wr_ctl5;
	logic wr_log;
	assign wr_ctl4 = i_reg_wr && i_reg_addr == vme_window_pkg::OFS_WINDOW4_CONTROL;
	assign wr_ctl5 = i_reg_wr && i_reg_addr == vme_window_pkg::OFS_WINDOW5_CONTROL;
	assign wr_log = i_reg_wr && i_reg_addr == vme_window_pkg::OFS_MODIFIER_FAULT_LOG;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic vme_window_pkg::window_ctl_t ctl_from(input logic [31:0] d);
		vme_window_pkg::window_ctl_t c;
		c.active = d[vme_window_pkg::CTL_ACTIVE];
		c.posted = d[vme_window_pkg::CTL_POSTED];
		c.prefetch = d[vme_window_pkg::CTL_PREFETCH];
		c.pd_sel = d[vme_window_pkg::CTL_PD_LSB +: 2];
		c.priv = d[vme_window_pkg::CTL_PRIV_LSB +: 2];
		c.space = d[vme_window_pkg::CTL_SPACE_LSB +: 3];
		c.wide = d[vme_window_pkg::CTL_WIDE];
		c.lock = d[vme_window_pkg::CTL_LOCK];
		c.pci_space = d[vme_window_pkg::CTL_PCI_LSB +: 2];
		return c;
	endfunction : ctl_from

	function automatic logic [31:0] ctl_to(input vme_window_pkg::window_ctl_t c);
		logic [31:0] d;
		d = 32'h0;
		d[vme_window_pkg::CTL_ACTIVE] = c.active;
		d[vme_window_pkg::CTL_POSTED] = c.posted;
		d[vme_window_pkg::CTL_PREFETCH] = c.prefetch;
		d[vme_window_pkg::CTL_PD_LSB +: 2] = c.pd_sel;
		d[vme_window_pkg::CTL_PRIV_LSB +: 2] = c.priv;
		d[vme_window_pkg::CTL_SPACE_LSB +: 3] = c.space;
		d[vme_window_pkg::CTL_WIDE] = c.wide;
		d[vme_window_pkg::CTL_LOCK] = c.lock;
		d[vme_window_pkg::CTL_PCI_LSB +: 2] = c.pci_space;
		return d;
	endfunction : ctl_to

	// Modifier code and space acceptance
	function automatic logic am_match(input vme_window_pkg::window_ctl_t c,
			input logic [5:0] am, input logic allow_a16);
		logic sp_ok;
		logic std;
		logic pd_ok;
		logic pr_ok;
		std = 1'b1;
		case (c.space)
			vme_window_pkg::SPACE_A16: sp_ok = allow_a16 && am[5:3] == vme_window_pkg::AM_GRP_A16;
			vme_window_pkg::SPACE_A24: sp_ok = am[5:3] == vme_window_pkg::AM_GRP_A24;
			vme_window_pkg::SPACE_A32: sp_ok = am[5:3] == vme_window_pkg::AM_GRP_A32;
			vme_window_pkg::SPACE_CUSTOM_ONE: begin
				sp_ok = am[5:3] == vme_window_pkg::AM_GRP_CUSTOM_ONE;
				std = 1'b0;
			end
			vme_window_pkg::SPACE_CUSTOM_TWO: begin
				sp_ok = am[5:3] == vme_window_pkg::AM_GRP_CUSTOM_TWO;
				std = 1'b0;
			end
			default: sp_ok = 1'b0;
		endcase
		pd_ok = (am[1:0] == 2'h1 && c.pd_sel[0]) || (am[1:0] == 2'h2 && c.pd_sel[1]);
		pr_ok = am[2] ? c.priv[1] : c.priv[0];
		return sp_ok && (!std || (pd_ok && pr_ok));
	endfunction : am_match

	// Address as seen in the selected space
	function automatic logic [31:0] space_addr(input logic [2:0] space, input logic [31:0] a);
		logic [31:0] r;
		r = a;
		if (space == vme_window_pkg::SPACE_A16) begin
			r = {16'h0, a[15:0]};
		end else if (space == vme_window_pkg::SPACE_A24) begin
			r = {8'h0, a[23:0]};
		end
		return r;
	endfunction : space_addr

	// ----------------------------------------
	// Window control registers
	// ----------------------------------------
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			ctl4 <= vme_window_pkg::RST_CTL;
			ctl5 <= vme_window_pkg::RST_CTL;
		end else begin
			if (wr_ctl4) begin
				ctl4 <= ctl_from(i_reg_wdata);
			end
			if (wr_ctl5) begin
				ctl5 <= ctl_from(i_reg_wdata);
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (rst) begin
			base4 <= 20'h0;
			bound4 <= 20'h0;
			offset4 <= 20'h0;
		end else if (i_reg_wr) begin
			if (i_reg_addr == vme_window_pkg::OFS_WINDOW4_BASE) begin
				base4 <= i_reg_wdata[31:vme_window_pkg::W4_GRAIN];
			end
			if (i_reg_addr == vme_window_pkg::OFS_WINDOW4_BOUND) begin
				bound4 <= i_reg_wdata[31:vme_window_pkg::W4_GRAIN];
			end
			if (i_reg_addr == vme_window_pkg::OFS_WINDOW4_OFFSET) begin
				offset4 <= i_reg_wdata[31:vme_window_pkg::W4_GRAIN];
			end
		end
	end

	// ----------------------------------------
	// Posted write fault log
	// ----------------------------------------
	// A new error beats a clear arriving in the same cycle
	always_ff @(posedge i_mclk) begin
		if (rst) begin
			fault_addr <= 31'h0;
			fault_am <= 6'h0;
			fault_iack <= 1'b0;
			fault_valid <= 1'b0;
			fault_multi <= 1'b0;
		end else begin
			if (i_pw_berr && fault_valid && !(wr_log && i_reg_wdata[vme_window_pkg::LOG_VALID])) begin
				fault_multi <= 1'b1;
			end else if (i_pw_berr) begin
				fault_addr <= i_pw_berr_addr[31:1];
				fault_am <= i_pw_berr_am;
				fault_iack <= i_pw_berr_iack;
				fault_valid <= 1'b1;
				fault_multi <= 1'b0;
			end else if (wr_log && i_reg_wdata[vme_window_pkg::LOG_VALID]) begin
				fault_valid <= 1'b0;
				fault_multi <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0;
		unique case (i_reg_addr)
			vme_window_pkg::OFS_MODIFIER_FAULT_LOG: begin
				next_rdata[vme_window_pkg::LOG_AM_LSB +: 6] = fault_am;
				next_rdata[vme_window_pkg::LOG_IACK] = fault_iack;
				next_rdata[vme_window_pkg::LOG_MULTI] = fault_multi;
				next_rdata[vme_window_pkg::LOG_VALID] = fault_valid;
			end
			vme_window_pkg::OFS_ADDRESS_FAULT_LOG: next_rdata = {fault_addr, 1'b0};
			vme_window_pkg::OFS_WINDOW4_CONTROL: next_rdata = ctl_to(ctl4);
			vme_window_pkg::OFS_WINDOW4_BASE: next_rdata = {base4, 12'h0};
			vme_window_pkg::OFS_WINDOW4_BOUND: next_rdata = {bound4, 12'h0};
			vme_window_pkg::OFS_WINDOW4_OFFSET: next_rdata = {offset4, 12'h0};
			vme_window_pkg::OFS_WINDOW5_CONTROL: next_rdata = ctl_to(ctl5);
			default: next_rdata = 32'h0;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (rst) begin
			o_reg_rdata <= 32'h0;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			o_reg_rdata <= i_reg_rd ? next_rdata : 32'h0;
		end
	end

	// ----------------------------------------
	// Window decode
	// ----------------------------------------
	logic [31:0] a4;
	logic [31:0] a5;
	logic in4;
	logic in5;
	logic hit4;
	logic hit5;
	vme_window_pkg::window_ctl_t sel;
	vme_window_pkg::dec_result_t next_dec;

	assign a4 = space_addr(ctl4.space, i_vme_addr);
	assign a5 = space_addr(ctl5.space, i_vme_addr);
	assign in4 = a4 >= {base4, 12'h0} && (bound4 == 20'h0 || a4 < {bound4, 12'h0});
	assign in5 = a5 >= {i_w5_base, 16'h0} &&
		(i_w5_bound == 16'h0 || a5 < {i_w5_bound, 16'h0});
	assign hit4 = i_pci_master_allow && ctl4.active && in4 && am_match(ctl4, i_vme_am, 1'b1);
	assign hit5 = i_pci_master_allow && ctl5.active && in5 && am_match(ctl5, i_vme_am, 1'b0);
	assign sel = hit4 ? ctl4 : ctl5;

	always_comb begin
		next_dec = '0;
		next_dec.hit4 = hit4;
		next_dec.hit5 = hit5 && !hit4;
		if (hit4) begin
			next_dec.pci_addr = {a4[31:12] + offset4, a4[11:0]};
		end else if (hit5) begin
			next_dec.pci_addr = {a5[31:16] + i_w5_offset, a5[15:0]};
		end
		if (hit4 || hit5) begin
			next_dec.pci_space = sel.pci_space;
			next_dec.post = i_vme_write && sel.posted &&
				sel.pci_space == vme_window_pkg::PCI_MEM;
			next_dec.prefetch = !i_vme_write && sel.prefetch;
			next_dec.wide = sel.wide;
			next_dec.lock = i_vme_rmw && sel.lock;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (rst) begin
			o_dec_valid <= 1'b0;
			o_dec <= '0;
		end else begin
			o_dec_valid <= i_vme_req;
			o_dec <= i_vme_req ? next_dec : '0;
		end
	end

endmodule : vme_slave_window_decode

// *** test/vme_window_checker.sv ***
// Port assertions for the slave window decode block
`timescale 1ns/1ps
module vme_window_checker (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_vme_sysrst_n,
	input wire logic i_reg_rd,
	input wire logic o_reg_rvalid,
	input wire logic [31:0] o_reg_rdata,
	input wire logic i_pci_master_allow,
	input wire logic i_vme_req,
	input wire logic i_vme_write,
	input wire logic i_vme_rmw,
	input wire logic o_dec_valid,
	input wire vme_window_pkg::dec_result_t o_dec
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n || !i_vme_sysrst_n);
	sequence s_answer;
		##1 o_dec_valid;
	endsequence
	sequence s_miss;
		##1 o_dec_valid && !o_dec.hit4 && !o_dec.hit5;
	endsequence
	property p_dec_lat;
		i_vme_req |-> s_answer;
	endproperty
	a_dec_lat: assert property (p_dec_lat)
		else $error("decode answer missing");
	property p_no_master;
		i_vme_req && !i_pci_master_allow |-> s_miss;
	endproperty
	a_no_master: assert property (p_no_master)
		else $error("hit without master allow");
	property p_post_mem;
		o_dec.post |-> o_dec.pci_space == vme_window_pkg::PCI_MEM && $past(i_vme_write);
	endproperty
	a_post_mem: assert property (p_post_mem)
		else $error("posted outside memory space");
	property p_lock;
		o_dec.lock |-> $past(i_vme_rmw) && o_dec_valid;
	endproperty
	a_lock: assert property (p_lock)
		else $error("lock without rmw");
	property p_prefetch;
		o_dec.prefetch |-> !$past(i_vme_write) && (o_dec.hit4 || o_dec.hit5);
	endproperty
	a_prefetch: assert property (p_prefetch)
		else $error("prefetch on write or miss");
	property p_wide;
		o_dec.wide |-> o_dec.hit4 || o_dec.hit5;
	endproperty
	a_wide: assert property (p_wide)
		else $error("wide flag without hit");
	property p_rd_lat;
		i_reg_rd |=> o_reg_rvalid ##1 !o_reg_rvalid || $past(i_reg_rd);
	endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read answer timing");
	property p_reset;
		disable iff (1'b0)
		(!i_rst_n || !i_vme_sysrst_n) |=> !o_dec_valid && !o_reg_rvalid && o_reg_rdata == 32'h0;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs active after reset");
endmodule : vme_window_checker

bind vme_slave_window_decode vme_window_checker i_checker (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
	.i_vme_sysrst_n(i_vme_sysrst_n), .i_reg_rd(i_reg_rd), .o_reg_rvalid(o_reg_rvalid),
	.o_reg_rdata(o_reg_rdata), .i_pci_master_allow(i_pci_master_allow), .i_vme_req(i_vme_req),
	.i_vme_write(i_vme_write), .i_vme_rmw(i_vme_rmw), .o_dec_valid(o_dec_valid), .o_dec(o_dec));

// *** test/vme_master_model.sv ***
// Behavioural VMEbus master issuing cycles and bus error reports
`timescale 1ns/1ps
module vme_master_model (
	input wire logic i_mclk,
	output logic o_req,
	output logic [31:0] o_addr,
	output logic [5:0] o_am,
	output logic o_write,
	output logic o_rmw,
	output logic o_berr,
	output logic [31:0] o_berr_addr,
	output logic [5:0] o_berr_am,
	output logic o_berr_iack
);
	initial begin
		{o_req, o_addr, o_am, o_write, o_rmw} = '0;
		{o_berr, o_berr_addr, o_berr_am, o_berr_iack} = '0;
	end
	// Lines are scrambled once released
	task automatic issue(input logic [31:0] a, input logic [5:0] m, input logic w, input logic r);
		@(posedge i_mclk) #1;
		{o_req, o_addr, o_am, o_write, o_rmw} = {1'b1, a, m, w, r};
		@(posedge i_mclk) #1;
		{o_req, o_addr, o_am, o_write, o_rmw} = {1'b0, ~a, ~m, ~w, ~r};
	endtask : issue
	task automatic fault(input logic [31:0] a, input logic [5:0] m, input logic k);
		@(posedge i_mclk) #1;
		{o_berr, o_berr_addr, o_berr_am, o_berr_iack} = {1'b1, a, m, k};
		@(posedge i_mclk) #1;
		{o_berr, o_berr_addr, o_berr_am, o_berr_iack} = {1'b0, ~a, ~m, ~k};
	endtask : fault
endmodule : vme_master_model

// *** test/vme_slave_window_decode_test.sv ***
// Self-checking bench for the slave window decode block
`timescale 1ns/1ps
module vme_slave_window_decode_test;
	logic i_mclk = 1'b0;
	logic rst_n = 1'b0;
	logic sys_n = 1'b0;
	logic [11:0] ra = 12'h0;
	logic rwr = 1'b0;
	logic rrd = 1'b0;
	logic [31:0] wd = 32'h0;
	logic allow = 1'b1;
	logic [15:0] w5_lo = 16'h4000;
	logic [15:0] w5_hi = 16'h4100;
	logic [15:0] w5_add = 16'h0001;
	logic [31:0] rdata, va, ba;
	logic rvalid, req, wr, rmw, berr, iack, dv;
	logic [5:0] am, bam;
	vme_window_pkg::dec_result_t dec_o;
	int errors = 0;
	int checked = 0;
	vme_slave_window_decode i_dut (.i_mclk(i_mclk), .i_rst_n(rst_n), .i_vme_sysrst_n(sys_n),
		.i_reg_addr(ra), .i_reg_wr(rwr), .i_reg_rd(rrd), .i_reg_wdata(wd),
		.o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_pci_master_allow(allow),
		.i_pw_berr(berr), .i_pw_berr_addr(ba), .i_pw_berr_am(bam), .i_pw_berr_iack(iack),
		.i_w5_base(w5_lo), .i_w5_bound(w5_hi), .i_w5_offset(w5_add), .i_vme_req(req),
		.i_vme_addr(va), .i_vme_am(am), .i_vme_write(wr), .i_vme_rmw(rmw),
		.o_dec_valid(dv), .o_dec(dec_o));
	vme_master_model i_master (.i_mclk(i_mclk), .o_req(req), .o_addr(va), .o_am(am),
		.o_write(wr), .o_rmw(rmw), .o_berr(berr), .o_berr_addr(ba), .o_berr_am(bam),
		.o_berr_iack(iack));
	initial forever #5 i_mclk = ~i_mclk;
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : finish_test
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic await(input logic s);
		errors += (s !== 1'b1);
		if (s !== 1'b1) $display("[FAIL] handshake expected 1 seen %b", s);
		if (s !== 1'b1) finish_test();
	endtask : await
	task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge i_mclk) #1;
		{rwr, ra, wd} = {1'b1, a, d};
		@(posedge i_mclk) #1;
		rwr = 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge i_mclk) #1;
		{rrd, ra} = {1'b1, a};
		@(posedge i_mclk) #1;
		rrd = 1'b0;
		for (int n = 0; n < 4 && rvalid !== 1'b1; n++) @(posedge i_mclk) #1;
		await(rvalid);
		cmp($sformatf("reg %h", a), e, rdata);
	endtask : reg_rd
	task automatic dec(input logic [31:0] a, input logic [5:0] m, input logic w, input logic r,
		input logic [7:0] e, input logic [31:0] pa);
		i_master.issue(a, m, w, r);
		for (int n = 0; n < 4 && dv !== 1'b1; n++) @(posedge i_mclk) #1;
		await(dv);
		cmp("hit space post prefetch wide lock", 32'(e), 32'({dec_o.hit4, dec_o.hit5,
			dec_o.pci_space, dec_o.post, dec_o.prefetch, dec_o.wide, dec_o.lock}));
		if (e[7:6] != 2'b00) cmp("pci address", pa, dec_o.pci_addr);
	endtask : dec
	task automatic mode(input logic [31:0] c, input logic [5:0] m, input logic h);
		reg_wr(12'hf90, c);
		dec(32'h00001000, m, 1'b0, 1'b0, {h, 7'b0}, 32'h00001000);
	endtask : mode
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [11:0] z [6] = '{12'hf94, 12'hf98, 12'hf9c, 12'hf8c, 12'hf88, 12'hf80};
		reg_rd(12'hf90, 32'h00f00000);
		reg_rd(12'hfa4, 32'h00f00000);
		foreach (z[i]) reg_rd(z[i], 32'h0);
		$display("reset values done");
	endtask : t_reset
	task automatic t_decode();
		reg_wr(12'hf94, 32'h00100abc);
		reg_rd(12'hf94, 32'h00100000);
		reg_wr(12'hf98, 32'h00200000);
		reg_wr(12'hf9c, 32'hfff00000);
		reg_wr(12'hf90, 32'he0f200c0);
		dec(32'h00100000, 6'h0d, 1'b1, 1'b1, 8'b10001011, 32'h0);
		dec(32'h001ffffc, 6'h0d, 1'b0, 1'b0, 8'b10000110, 32'h000ffffc);
		dec(32'h00200000, 6'h0d, 1'b0, 1'b0, 8'h00, 32'h0);
		dec(32'h000fffff, 6'h0d, 1'b1, 1'b0, 8'h00, 32'h0);
		for (int s = 1; s < 3; s++) begin
			reg_wr(12'hf90, 32'he0f200c0 | 32'(s));
			dec(32'h00100000, 6'h0d, 1'b1, 1'b0, {2'b10, 2'(s), 4'b0010}, 32'h0);
		end
		allow = 1'b0;
		dec(32'h00100000, 6'h0d, 1'b1, 1'b0, 8'h00, 32'h0);
		allow = 1'b1;
		reg_wr(12'hf98, 32'h0);
		dec(32'hfffff000, 6'h0d, 1'b0, 1'b0, 8'b10100110, 32'hffeff000);
		reg_wr(12'hf90, 32'h0);
		dec(32'h00100000, 6'h0d, 1'b0, 1'b0, 8'h00, 32'h0);
		reg_wr(12'hfa4, 32'h80f20000);
		dec(32'h40000010, 6'h0d, 1'b0, 1'b0, 8'b01000000, 32'h40010010);
		dec(32'h40000020, 6'h0d, 1'b1, 1'b0, 8'b01000000, 32'h40010020);
		dec(32'h41000000, 6'h0d, 1'b0, 1'b0, 8'h00, 32'h0);
		$display("decode done");
	endtask : t_decode
	task automatic t_modes();
		reg_wr(12'hfa4, 32'h0);
		reg_wr(12'hf94, 32'h0);
		reg_wr(12'hf9c, 32'h0);
		mode(32'h80720000, 6'h0d, 1'b1);
		mode(32'h80720000, 6'h0e, 1'b0);
		mode(32'h80b20000, 6'h0e, 1'b1);
		mode(32'h80b20000, 6'h0d, 1'b0);
		mode(32'h80d20000, 6'h09, 1'b1);
		mode(32'h80d20000, 6'h0d, 1'b0);
		mode(32'h80e20000, 6'h0d, 1'b1);
		mode(32'h80e20000, 6'h09, 1'b0);
		mode(32'h80f10000, 6'h3d, 1'b1);
		mode(32'h80f10000, 6'h0d, 1'b0);
		mode(32'h80f00000, 6'h2d, 1'b1);
		mode(32'h80f60000, 6'h10, 1'b1);
		mode(32'h80f70000, 6'h18, 1'b1);
		mode(32'h80f30000, 6'h0d, 1'b0);
		w5_lo = 16'h0;
		reg_wr(12'hfa4, 32'h80f00000);
		dec(32'h00000010, 6'h2d, 1'b0, 1'b0, 8'h00, 32'h0);
		w5_lo = 16'h4000;
		$display("modifier modes done");
	endtask : t_modes
	task automatic t_fault();
		i_master.fault(32'h12345679, 6'h0d, 1'b1);
		reg_rd(12'hf8c, 32'h12345678);
		reg_rd(12'hf88, 32'h36800000);
		i_master.fault(32'h0000aaaa, 6'h3d, 1'b0);
		reg_rd(12'hf8c, 32'h12345678);
		reg_rd(12'hf88, 32'h37800000);
		reg_wr(12'hf88, 32'h0);
		reg_rd(12'hf88, 32'h37800000);
		reg_wr(12'hf88, 32'h00800000);
		i_master.fault(32'h0000aaaa, 6'h3d, 1'b0);
		reg_rd(12'hf8c, 32'h0000aaaa);
		reg_rd(12'hf88, 32'hf4800000);
		$display("fault log done");
	endtask : t_fault
	task automatic t_sysrst();
		reg_wr(12'hf90, 32'he0f200c0);
		@(posedge i_mclk) #1;
		sys_n = 1'b0;
		@(posedge i_mclk) #1;
		sys_n = 1'b1;
		reg_rd(12'hf90, 32'h00f00000);
		reg_rd(12'hf88, 32'h0);
		$display("system reset done");
	endtask : t_sysrst
	initial begin
		repeat (16) @(posedge i_mclk);
		#1;
		{rst_n, sys_n} = 2'b11;
		t_reset();
		t_decode();
		t_modes();
		t_fault();
		t_sysrst();
		finish_test();
	end
endmodule : vme_slave_window_decode_test
